// file: aas_pkg.sv
package aas_pkg;
    // register offsets (byte offset == 4 * word index here, 8-bit data in low bits)
    localparam logic [3:0] ADDR_CTRL0 = 4'h0;
    localparam logic [3:0] ADDR_CTRL2 = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    localparam logic [3:0] ADDR_MASK = 4'hC;
    // converter_control_zero fields
    localparam int GO_BIT = 1;
    localparam int ON_BIT = 0;
    // converter_control_two fields
    localparam int ACQ_LSB = 3;
    localparam int CS_LSB = 0;
    localparam logic [7:0] CTRL2_WMASK = 8'hBF;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    // status fields
    localparam int DONE_BIT = 0;
    localparam logic [7:0] STAT_WMASK = 8'h01;
    localparam logic [2:0] ACQ_MANUAL = 3'h0;
    localparam logic [1:0] CS_RC_CODE = 2'h3;
    localparam logic [4:0] CONV_PERIODS = 5'h0D;
    localparam logic [4:0] GAP_PERIODS = 5'h02;
    // one instruction cycle = four oscillator periods
    localparam logic [7:0] TCY_OSC = 8'h04;
    localparam logic [7:0] DIV_MAX = 8'h40;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ACQ = 5'b00010,
        ST_RCDLY = 5'b00100,
        ST_CONV = 5'b01000,
        ST_GAP = 5'b10000
    } aas_state_t;

    typedef struct packed {
        aas_state_t st;
        logic [7:0] ctrl0;
        logic [7:0] ctrl2;
        logic [7:0] stat;
        logic [7:0] mask;
        logic [7:0] rdata;
        logic [7:0] div_cnt;
        logic [4:0] per_cnt;
        logic hold_conn;
        logic conv_act;
        logic irq;
    } aas_regs_t;

    // bit periods of acquisition select
    function automatic logic [4:0] acq_periods(input logic [2:0] sel);
        case (sel)
            3'h1: acq_periods = 5'h02;
            3'h2: acq_periods = 5'h04;
            3'h3: acq_periods = 5'h06;
            3'h4: acq_periods = 5'h08;
            3'h5: acq_periods = 5'h0C;
            3'h6: acq_periods = 5'h10;
            3'h7: acq_periods = 5'h14;
            default: acq_periods = 5'h00;
        endcase
    endfunction

    // oscillator periods per bit period
    function automatic logic [7:0] osc_div(input logic [2:0] sel);
        case (sel)
            3'h0: osc_div = 8'h02;
            3'h4: osc_div = 8'h04;
            3'h1: osc_div = 8'h08;
            3'h5: osc_div = 8'h10;
            3'h2: osc_div = 8'h20;
            3'h6: osc_div = 8'h40;
            default: osc_div = 8'h02;
        endcase
    endfunction
endpackage

// file: aas_adc_acquisition_sequencer.sv
`timescale 1ns/1ps
// Operation
// R1: programmed acquisition then automatic conversion start
// R2: acquisition select at control-two bits 5:3
// R3: select 000: go starts conversion immediately
// R4: acquisition select resets to 000
// R5: software waits acquisition before go manually
// R6: completion clears go, sets done, resamples
// R7: no acquisition-end status; go stays set
// R8: conversion lasts 13 bit periods
// R9: clock select maps dividers and RC
// R10: software picks shortest legal bit period
// R11: RC above 1 MHz needs sleep
// R12: hold capacitor disconnects at conversion start
// R13: software samples new channel long enough
// R14: acquisition encodings 2..20 bit periods
// R15: RC clock adds one instruction cycle
// R16: two bit periods after completion before acquisition
// R17: reset clears registers, aborts conversion
// R18: phases counted in whole bit periods
module aas_adc_acquisition_sequencer #(
    parameter int RC_WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic rc_tick,
    output logic [7:0] rdata,
    output logic hold_connected,
    output logic conversion_active,
    output logic irq
);
    initial begin
        if (RC_WIDTH != 1) $error("rc tick must be one bit");
    end

    aas_pkg::aas_regs_t r_r;
    aas_pkg::aas_regs_t r_nxt;
    logic tick;
    logic [2:0] cs;
    logic use_rc;
    logic done_ev;

    assign cs = r_r.ctrl2[aas_pkg::CS_LSB +: 3];
    assign use_rc = (cs[1:0] == aas_pkg::CS_RC_CODE); // [R9]

    // --------------------------------------------------
    // sequencer and registers
    // --------------------------------------------------
    always_comb begin
        r_nxt = r_r;
        done_ev = 1'b0;
        // bit period tick: divided oscillator or rc source [R18]
        tick = use_rc ? rc_tick : (r_r.div_cnt == aas_pkg::osc_div(cs) - 8'h01); // [R9]
        if (r_r.st == aas_pkg::ST_IDLE || r_r.st == aas_pkg::ST_RCDLY) begin
            r_nxt.div_cnt = r_r.div_cnt + 8'h01;
        end else if (use_rc || tick) begin
            r_nxt.div_cnt = 8'h00;
        end else begin
            r_nxt.div_cnt = r_r.div_cnt + 8'h01;
        end
        case (r_r.st)
            aas_pkg::ST_IDLE: begin
                r_nxt.div_cnt = 8'h00;
                if (r_r.ctrl0[aas_pkg::GO_BIT] && r_r.ctrl0[aas_pkg::ON_BIT]) begin
                    r_nxt.per_cnt = 5'h00;
                    if (use_rc) begin
                        r_nxt.st = aas_pkg::ST_RCDLY; // [R15]
                    end else if (r_r.ctrl2[aas_pkg::ACQ_LSB +: 3] == aas_pkg::ACQ_MANUAL) begin
                        r_nxt.st = aas_pkg::ST_CONV; // [R3]
                        r_nxt.hold_conn = 1'b0; // [R12]
                        r_nxt.conv_act = 1'b1;
                    end else begin
                        r_nxt.st = aas_pkg::ST_ACQ; // [R1]
                    end
                end
            end
            aas_pkg::ST_RCDLY: begin
                if (r_r.div_cnt >= aas_pkg::TCY_OSC - 8'h01) begin // [R15]
                    r_nxt.div_cnt = 8'h00;
                    if (r_r.ctrl2[aas_pkg::ACQ_LSB +: 3] == aas_pkg::ACQ_MANUAL) begin
                        r_nxt.st = aas_pkg::ST_CONV; // [R3]
                        r_nxt.hold_conn = 1'b0; // [R12]
                        r_nxt.conv_act = 1'b1;
                    end else begin
                        r_nxt.st = aas_pkg::ST_ACQ;
                    end
                end
            end
            aas_pkg::ST_ACQ: begin
                if (tick) begin
                    r_nxt.per_cnt = r_r.per_cnt + 5'h01;
                    if (r_r.per_cnt + 5'h01 >= aas_pkg::acq_periods(r_r.ctrl2[aas_pkg::ACQ_LSB +: 3])) begin // [R14]
                        r_nxt.st = aas_pkg::ST_CONV; // [R1]
                        r_nxt.per_cnt = 5'h00;
                        r_nxt.hold_conn = 1'b0; // [R12]
                        r_nxt.conv_act = 1'b1;
                    end
                end
            end
            aas_pkg::ST_CONV: begin
                if (tick) begin
                    r_nxt.per_cnt = r_r.per_cnt + 5'h01;
                    if (r_r.per_cnt + 5'h01 == aas_pkg::CONV_PERIODS) begin // [R8]
                        r_nxt.st = aas_pkg::ST_GAP;
                        r_nxt.per_cnt = 5'h00;
                        r_nxt.hold_conn = 1'b1; // [R6]
                        r_nxt.conv_act = 1'b0;
                        done_ev = 1'b1;
                    end
                end
            end
            aas_pkg::ST_GAP: begin
                if (tick) begin
                    r_nxt.per_cnt = r_r.per_cnt + 5'h01;
                    if (r_r.per_cnt + 5'h01 == aas_pkg::GAP_PERIODS) begin // [R16]
                        r_nxt.st = aas_pkg::ST_IDLE;
                        r_nxt.per_cnt = 5'h00;
                    end
                end
            end
            default: begin
                r_nxt.st = aas_pkg::ST_IDLE;
            end
        endcase

        // software writes; go may not be set during the gap [R16]
        if (wr_en) begin
            case (addr)
                aas_pkg::ADDR_CTRL0: begin
                    r_nxt.ctrl0[aas_pkg::ON_BIT] = wdata[aas_pkg::ON_BIT];
                    if (r_r.st == aas_pkg::ST_IDLE) begin
                        r_nxt.ctrl0[aas_pkg::GO_BIT] = wdata[aas_pkg::GO_BIT];
                    end
                end
                aas_pkg::ADDR_CTRL2: r_nxt.ctrl2 = wdata & aas_pkg::CTRL2_WMASK; // [R2]
                aas_pkg::ADDR_STAT: r_nxt.stat = r_r.stat & ~(wdata & aas_pkg::STAT_WMASK);
                aas_pkg::ADDR_MASK: r_nxt.mask = wdata & aas_pkg::STAT_WMASK;
                default: begin
                end
            endcase
        end
        if (!r_r.ctrl0[aas_pkg::ON_BIT] && r_r.st != aas_pkg::ST_IDLE) begin
            r_nxt.st = aas_pkg::ST_IDLE;
            // abort drops go so that turning on again does not restart
            r_nxt.ctrl0[aas_pkg::GO_BIT] = 1'b0;
            r_nxt.hold_conn = 1'b1;
            r_nxt.conv_act = 1'b0;
        end
        // go stays set through acquisition and conversion [R7]
        if (done_ev) begin
            r_nxt.ctrl0[aas_pkg::GO_BIT] = 1'b0; // [R6]
            r_nxt.stat[aas_pkg::DONE_BIT] = 1'b1; // set wins over clear [R6]
        end
        r_nxt.irq = |(r_nxt.stat & r_nxt.mask);

        r_nxt.rdata = 8'h00;
        if (rd_en) begin
            case (addr)
                aas_pkg::ADDR_CTRL0: r_nxt.rdata = r_r.ctrl0;
                aas_pkg::ADDR_CTRL2: r_nxt.rdata = r_r.ctrl2;
                aas_pkg::ADDR_STAT: r_nxt.rdata = r_r.stat;
                aas_pkg::ADDR_MASK: r_nxt.rdata = r_r.mask;
                default: r_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            r_r <= '0; // [R17]
            r_r.st <= aas_pkg::ST_IDLE;
            r_r.ctrl2 <= aas_pkg::CTRL2_RST; // [R4]
            r_r.hold_conn <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign rdata = r_r.rdata;
    assign hold_connected = r_r.hold_conn;
    assign conversion_active = r_r.conv_act;
    assign irq = r_r.irq;

    // --------------------------------------------------
    // assertions
    // --------------------------------------------------
    a_reset_manual: assert property (@(posedge core_clk) $fell(reset) |-> r_r.ctrl2 == 8'h00) // [R4]
        else $error("acquisition select not zero after reset");
    a_done_clears_go: assert property (@(posedge core_clk) disable iff (reset)
        $fell(r_r.conv_act) && r_r.st == aas_pkg::ST_GAP |-> !r_r.ctrl0[aas_pkg::GO_BIT]
        && r_r.stat[aas_pkg::DONE_BIT] && r_r.hold_conn) // [R6]
        else $error("completion did not clear go or set done");
    a_hold_split: assert property (@(posedge core_clk) disable iff (reset)
        r_r.conv_act |-> !r_r.hold_conn) // [R12]
        else $error("hold capacitor connected during conversion");
    a_go_during: assert property (@(posedge core_clk) disable iff (reset)
        (r_r.st == aas_pkg::ST_ACQ || r_r.st == aas_pkg::ST_CONV) |-> r_r.ctrl0[aas_pkg::GO_BIT]) // [R7]
        else $error("go cleared early");
    a_manual_start: assert property (@(posedge core_clk) disable iff (reset)
        r_r.st == aas_pkg::ST_IDLE && r_r.ctrl0[1:0] == 2'b11 && !use_rc && r_r.ctrl2[5:3] == 3'h0
        |=> r_r.conv_act) // [R3]
        else $error("manual go did not start conversion");
    a_auto_acq: assert property (@(posedge core_clk) disable iff (reset)
        r_r.st == aas_pkg::ST_IDLE && r_r.ctrl0[1:0] == 2'b11 && !use_rc && r_r.ctrl2[5:3] != 3'h0
        |=> r_r.st == aas_pkg::ST_ACQ && r_r.hold_conn) // [R1]
        else $error("programmed acquisition not entered");
    a_conv_len: assert property (@(posedge core_clk) disable iff (reset)
        $rose(r_r.conv_act) && r_r.ctrl2[2:0] == 3'h0 && r_r.ctrl0[0] && !wr_en |-> r_r.conv_act [*8]) // [R8]
        else $error("conversion ended too early");
    a_gap_len: assert property (@(posedge core_clk) disable iff (reset)
        r_r.st == aas_pkg::ST_CONV && r_nxt.st == aas_pkg::ST_GAP && r_r.ctrl2[2:0] == 3'h0
        |=> r_r.st == aas_pkg::ST_GAP [*4]) // [R16]
        else $error("gap shorter than two bit periods");
    a_rc_delay: assert property (@(posedge core_clk) disable iff (reset)
        r_r.st == aas_pkg::ST_IDLE && r_r.ctrl0[1:0] == 2'b11 && use_rc
        |=> r_r.st == aas_pkg::ST_RCDLY [*4]) // [R15]
        else $error("rc start delay missing");
    a_div_tick: assert property (@(posedge core_clk) disable iff (reset)
        r_r.st == aas_pkg::ST_CONV && !use_rc |-> r_r.div_cnt < aas_pkg::osc_div(cs)) // [R18]
        else $error("divider out of range");

    // --------------------------------------------------
    // assertions: states, flags and register port
    // --------------------------------------------------
    a_reset_state: assert property (@(posedge core_clk) // [R17]
        $fell(reset) |-> r_r.st == aas_pkg::ST_IDLE && r_r.hold_conn && !r_r.conv_act)
        else $error("state not cleared by reset");
    a_state_onehot: assert property (@(posedge core_clk) disable iff (reset)
        $onehot(r_r.st))
        else $error("state not one-hot");
    a_idle_quiet: assert property (@(posedge core_clk) disable iff (reset) // [R6]
        r_r.st == aas_pkg::ST_IDLE |-> !r_r.conv_act && r_r.hold_conn)
        else $error("idle sequencer not sampling");
    a_acq_sampling: assert property (@(posedge core_clk) disable iff (reset) // [R1]
        r_r.st == aas_pkg::ST_ACQ |-> r_r.hold_conn && !r_r.conv_act)
        else $error("hold capacitor split during acquisition");
    a_rcdly_sampling: assert property (@(posedge core_clk) disable iff (reset) // [R15]
        r_r.st == aas_pkg::ST_RCDLY |-> r_r.hold_conn && !r_r.conv_act)
        else $error("conversion began inside rc delay");
    a_rcdly_count: assert property (@(posedge core_clk) disable iff (reset) // [R15]
        r_r.st == aas_pkg::ST_RCDLY |-> r_r.div_cnt < aas_pkg::TCY_OSC)
        else $error("rc delay counter overran");
    a_rcdly_exit: assert property (@(posedge core_clk) disable iff (reset) // [R15]
        r_r.st == aas_pkg::ST_RCDLY && r_r.div_cnt == aas_pkg::TCY_OSC - 8'h01 && r_r.ctrl0[aas_pkg::ON_BIT]
        |=> r_r.st == aas_pkg::ST_ACQ || r_r.st == aas_pkg::ST_CONV)
        else $error("rc delay did not end after one instruction cycle");
    a_conv_state: assert property (@(posedge core_clk) disable iff (reset) // [R8]
        r_r.conv_act |-> r_r.st == aas_pkg::ST_CONV)
        else $error("conversion flag outside conversion state");
    a_conv_count: assert property (@(posedge core_clk) disable iff (reset) // [R8]
        r_r.st == aas_pkg::ST_CONV |-> r_r.per_cnt < aas_pkg::CONV_PERIODS)
        else $error("conversion period count overran");
    a_acq_count: assert property (@(posedge core_clk) disable iff (reset) // [R14]
        r_r.st == aas_pkg::ST_ACQ |-> r_r.per_cnt < aas_pkg::acq_periods(3'h7))
        else $error("acquisition period count overran");
    a_gap_count: assert property (@(posedge core_clk) disable iff (reset) // [R16]
        r_r.st == aas_pkg::ST_GAP |-> r_r.per_cnt < aas_pkg::GAP_PERIODS)
        else $error("gap period count overran");
    a_gap_no_conv: assert property (@(posedge core_clk) disable iff (reset) // [R16]
        r_r.st == aas_pkg::ST_GAP |-> !r_r.conv_act && r_r.hold_conn)
        else $error("conversion active during gap");
    a_gap_go_held: assert property (@(posedge core_clk) disable iff (reset) // [R16]
        r_r.st == aas_pkg::ST_GAP && !r_r.ctrl0[aas_pkg::GO_BIT] |=> !r_r.ctrl0[aas_pkg::GO_BIT])
        else $error("go accepted during gap");
    a_go_write_idle: assert property (@(posedge core_clk) disable iff (reset) // [R1]
        r_r.st == aas_pkg::ST_IDLE && wr_en && addr == aas_pkg::ADDR_CTRL0
        && wdata[aas_pkg::GO_BIT] && wdata[aas_pkg::ON_BIT] |=> r_r.ctrl0[aas_pkg::GO_BIT])
        else $error("go write refused while idle");
    a_hold_return: assert property (@(posedge core_clk) disable iff (reset) // [R6]
        $fell(r_r.conv_act) |-> r_r.hold_conn)
        else $error("sampling not resumed after conversion");
    a_done_set: assert property (@(posedge core_clk) disable iff (reset) // [R6]
        r_r.st == aas_pkg::ST_CONV && r_nxt.st == aas_pkg::ST_GAP |=> r_r.stat[aas_pkg::DONE_BIT])
        else $error("done flag not set on completion");
    a_done_sticky: assert property (@(posedge core_clk) disable iff (reset) // [R6]
        r_r.stat[aas_pkg::DONE_BIT] && !(wr_en && addr == aas_pkg::ADDR_STAT && wdata[aas_pkg::DONE_BIT])
        |=> r_r.stat[aas_pkg::DONE_BIT])
        else $error("done flag lost without a clear");
    a_done_clear: assert property (@(posedge core_clk) disable iff (reset) // [R6]
        wr_en && addr == aas_pkg::ADDR_STAT && wdata[aas_pkg::DONE_BIT] && !done_ev
        |=> !r_r.stat[aas_pkg::DONE_BIT])
        else $error("done flag not cleared by write of one");
    a_irq_level: assert property (@(posedge core_clk) disable iff (reset) // [R6]
        r_r.irq == |(r_r.stat & r_r.mask))
        else $error("interrupt level disagrees with status and mask");
    a_stat_bits: assert property (@(posedge core_clk) disable iff (reset)
        (r_r.stat & ~aas_pkg::STAT_WMASK) == 8'h00 && (r_r.mask & ~aas_pkg::STAT_WMASK) == 8'h00)
        else $error("unused status or mask bit set");
    a_ctrl2_bits: assert property (@(posedge core_clk) disable iff (reset) // [R2]
        (r_r.ctrl2 & ~aas_pkg::CTRL2_WMASK) == 8'h00)
        else $error("unimplemented control-two bit set");
    a_abort_idle: assert property (@(posedge core_clk) disable iff (reset)
        !r_r.ctrl0[aas_pkg::ON_BIT] && r_r.st != aas_pkg::ST_IDLE
        |=> r_r.st == aas_pkg::ST_IDLE && r_r.hold_conn && !r_r.ctrl0[aas_pkg::GO_BIT])
        else $error("turning off did not abort");
    a_rdata_idle: assert property (@(posedge core_clk) disable iff (reset)
        !rd_en |=> r_r.rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_rd_ctrl2: assert property (@(posedge core_clk) disable iff (reset) // [R2]
        rd_en && addr == aas_pkg::ADDR_CTRL2 |=> r_r.rdata == $past(r_r.ctrl2))
        else $error("control-two read data wrong");
    a_rd_stat: assert property (@(posedge core_clk) disable iff (reset) // [R6]
        rd_en && addr == aas_pkg::ADDR_STAT |=> r_r.rdata == $past(r_r.stat))
        else $error("status read data wrong");
endmodule // aas_adc_acquisition_sequencer

// file: aas_rc_osc.sv
`timescale 1ns/1ps
// ---------------------------------
// internal rc oscillator tick model
// ---------------------------------
module aas_rc_osc #(
    parameter int PERIOD = 10
) (
    input wire logic core_clk,
    input wire logic reset,
    output logic rc_tick
);
    int cnt;
    always_ff @(posedge core_clk) begin
        if (reset || cnt == PERIOD - 1) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
        rc_tick <= !reset && cnt == PERIOD - 1;
    end
endmodule // aas_rc_osc

// file: tb.sv
`timescale 1ns/1ps
module tb;
    logic core_clk = 0, reset = 1, wr_en = 0, rd_en = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, d;
    logic rc_tick, hold_connected, conversion_active, irq;
    int errors = 0, n_tests = 0, st, len, k;
    int divs[6] = '{2, 4, 8, 16, 32, 64};
    logic [2:0] cs[6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
    int acq[7] = '{2, 4, 6, 8, 12, 16, 20};
    always #2.5 core_clk = ~core_clk;
    aas_rc_osc #(.PERIOD(10)) rc (.core_clk(core_clk), .reset(reset), .rc_tick(rc_tick));
    aas_adc_acquisition_sequencer dut (.core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rc_tick(rc_tick), .rdata(rdata), .hold_connected(hold_connected),
        .conversion_active(conversion_active), .irq(irq));
    // ---------------------------------
    // shared tasks
    // ---------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask
    // start with go, measure cycles to conversion and its length
    task automatic run(input logic [7:0] c2, input int gap, output int s, output int l);
        wr(aas_pkg::ADDR_CTRL2, c2);
        wr(aas_pkg::ADDR_CTRL0, 8'h03);
        s = 0;
        l = 0;
        do begin @(posedge core_clk); #1 s++; end while (conversion_active !== 1'b1 && s < 3000);
        check("hold_in_conv", hold_connected, 16'h0);
        do begin @(posedge core_clk); #1 l++; end while (conversion_active === 1'b1 && l < 3000);
        check("hold_after", hold_connected, 16'h1);
        repeat (gap) @(posedge core_clk);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #300000;
        errors++;
        final_report;
    end
    // ---------------------------------
    // scenarios
    // ---------------------------------
    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        rd(aas_pkg::ADDR_CTRL2, d);
        check("ctrl2_rst", d, 16'h0);
        check("hold_rst", {conversion_active, hold_connected}, 16'h1);
        wr(aas_pkg::ADDR_CTRL2, 8'hFF);
        rd(aas_pkg::ADDR_CTRL2, d);
        check("ctrl2_rw", d, 16'hBF);
        rd(4'h2, d);
        check("unmapped", d, 16'h0);
        wr(aas_pkg::ADDR_MASK, 8'h01);
        for (int i = 0; i < 6; i++) begin
            run({5'h00, cs[i]}, 2 * divs[i] + 2, st, len);
            check("manual_start", st, 16'h1);
            check("conv_len", len, 16'(13 * divs[i]));
        end
        check("irq_set", irq, 16'h1);
        rd(aas_pkg::ADDR_CTRL0, d);
        check("go_clr", d, 16'h1);
        rd(aas_pkg::ADDR_STAT, d);
        check("done_set", d, 16'h1);
        wr(aas_pkg::ADDR_MASK, 8'h00);
        @(posedge core_clk);
        #1 check("irq_masked", irq, 16'h0);
        wr(aas_pkg::ADDR_MASK, 8'h01);
        wr(aas_pkg::ADDR_STAT, 8'h01);
        rd(aas_pkg::ADDR_STAT, d);
        check("done_clr", {d, 7'h00, irq}, 16'h0);
        for (int a = 1; a < 8; a++) begin
            run(8'(a << 3), 6, st, len);
            check("acq_start", st, 16'(1 + 2 * acq[a - 1]));
            check("acq_conv_len", len, 16'd26);
        end
        for (int c = 3; c < 8; c += 4) begin
            run(8'(c), 40, st, len);
            check("rc_delay", st >= 5, 16'h1);
            check("rc_len", len >= 120 && len <= 140, 16'h1);
        end
        wr(aas_pkg::ADDR_CTRL2, 8'h38);
        wr(aas_pkg::ADDR_CTRL0, 8'h03);
        rd(aas_pkg::ADDR_CTRL0, d);
        check("acq_status", {d, conversion_active, hold_connected}, 16'h000D);
        k = 0;
        do begin rd(aas_pkg::ADDR_CTRL0, d); k++; end while (d[1] !== 1'b0 && k < 500);
        check("poll_done", d, 16'h1);
        run(8'h00, 0, st, len);
        wr(aas_pkg::ADDR_CTRL0, 8'h03);
        rd(aas_pkg::ADDR_CTRL0, d);
        check("gap_go", {d, conversion_active}, 16'h2);
        repeat (6) @(posedge core_clk);
        wr(aas_pkg::ADDR_CTRL2, 8'h06);
        wr(aas_pkg::ADDR_CTRL0, 8'h03);
        repeat (20) @(posedge core_clk);
        wr(aas_pkg::ADDR_CTRL0, 8'h00);
        rd(aas_pkg::ADDR_CTRL0, d);
        check("abort", {d, conversion_active, hold_connected}, 16'h1);
        wr(aas_pkg::ADDR_CTRL0, 8'h03);
        repeat (20) @(posedge core_clk);
        reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        #1 check("reset_abort", {conversion_active, hold_connected}, 16'h1);
        rd(aas_pkg::ADDR_CTRL2, d);
        check("reset_ctrl2", d, 16'h0);
        final_report;
    end
endmodule // tb
